// File: rtl/ebrwc_defines.vh
// constants for the external bus ready wait-state controller
`ifndef EBRWC_DEFINES_VH
`define EBRWC_DEFINES_VH
`define EBRWC_PH_W      4
`define EBRWC_ST_W      3
`define EBRWC_ST_IDLE   3'h0
`define EBRWC_ST_PHASE  3'h1
`define EBRWC_ST_MAND   3'h2
`define EBRWC_ST_RDY    3'h3
`define EBRWC_ST_SYNC   3'h4
`define EBRWC_ST_DONE   3'h5
`define EBRWC_CNT_ZERO  4'h0
`define EBRWC_CNT_ONE   4'h1
`endif

// File: rtl/ebrwc_ready_ctrl.v
// ready-controlled wait-state sequencer for one external bus cycle
`timescale 1ns/10ps
`include "ebrwc_defines.vh"
module ebrwc_ready_ctrl #(
  parameter PH_W = `EBRWC_PH_W
) (
  input  wire            clk,
  input  wire            rst,
  input  wire            cycle_start,
  input  wire [PH_W-1:0] phase_len,
  input  wire [PH_W-1:0] mandatory_wait_phase,
  input  wire            ready_ctrl_en,
  input  wire            ready_active_high,
  input  wire            ready_async_mode,
  input  wire            ready_pin,
  output wire            bus_reference_clock_out,
  output reg             strobe_active,
  output reg             ready_wait_phase,
  output reg             cycle_done,
  output wire            busy
);

  reg [`EBRWC_ST_W-1:0] state;
  reg [`EBRWC_ST_W-1:0] next_state;
  reg [PH_W-1:0]        cnt;
  reg [PH_W-1:0]        next_cnt;
  reg                   async_mode;
  reg                   next_async_mode;
  reg                   sync_ff1;
  reg                   sync_ff2;
  reg                   sync_ff3;
  wire                  rdy_sync_lvl;
  wire                  rdy_async_lvl;
  wire                  rdy_now;

  // a sampled pin level counts as ready when it matches the chosen polarity
  function rdy_level;
    input lvl;
    input act_high;
    begin
      rdy_level = (lvl == act_high);
    end
  endfunction

  // the reference clock output is the system clock itself
  assign bus_reference_clock_out = clk;

  // two flops for any pin input, one more stage in async mode
  always @(posedge clk) begin
    if (rst) begin
      sync_ff1 <= 1'b0;
      sync_ff2 <= 1'b0;
      sync_ff3 <= 1'b0;
    end else begin
      sync_ff1 <= ready_pin;
      sync_ff2 <= sync_ff1;
      sync_ff3 <= sync_ff2;
    end
  end

  // polarity applied after the flops, so a polarity change costs no extra stage
  assign rdy_sync_lvl  = rdy_level(sync_ff2, ready_active_high);
  assign rdy_async_lvl = rdy_level(sync_ff3, ready_active_high);
  assign rdy_now       = async_mode ? rdy_async_lvl : rdy_sync_lvl;

  assign busy = (state != `EBRWC_ST_IDLE);

  always @* begin
    next_state      = state;
    next_cnt        = cnt;
    next_async_mode = async_mode;
    case (state)
      `EBRWC_ST_IDLE: begin
        if (cycle_start) begin
          next_async_mode = ready_async_mode;
          next_cnt        = phase_len;
          next_state      = (phase_len == `EBRWC_CNT_ZERO) ? `EBRWC_ST_MAND
                                                           : `EBRWC_ST_PHASE;
          if (phase_len == `EBRWC_CNT_ZERO) begin
            next_cnt = mandatory_wait_phase;
          end
        end
      end
      `EBRWC_ST_PHASE: begin
        if (cnt == `EBRWC_CNT_ONE) begin
          next_cnt   = mandatory_wait_phase;
          next_state = `EBRWC_ST_MAND;
        end else begin
          next_cnt = cnt - `EBRWC_CNT_ONE;
        end
      end
      `EBRWC_ST_MAND: begin
        if (cnt == `EBRWC_CNT_ZERO || cnt == `EBRWC_CNT_ONE) begin
          if (!ready_ctrl_en) begin
            next_state = `EBRWC_ST_DONE;
          end else if (async_mode) begin
            next_state = `EBRWC_ST_SYNC;
          end else begin
            next_state = `EBRWC_ST_RDY;
          end
          next_cnt = `EBRWC_CNT_ZERO;
        end else begin
          next_cnt = cnt - `EBRWC_CNT_ONE;
        end
      end
      `EBRWC_ST_SYNC: begin
        // one forced wait lets the extra stage catch up before deciding
        next_state = `EBRWC_ST_RDY;
      end
      `EBRWC_ST_RDY: begin
        if (rdy_now) begin
          next_state = `EBRWC_ST_DONE;
        end
      end
      `EBRWC_ST_DONE: begin
        next_state = `EBRWC_ST_IDLE;
      end
      default: begin
        next_state = `EBRWC_ST_IDLE;
        next_cnt   = `EBRWC_CNT_ZERO;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state            <= `EBRWC_ST_IDLE;
      cnt              <= `EBRWC_CNT_ZERO;
      async_mode       <= 1'b0;
      strobe_active    <= 1'b0;
      ready_wait_phase <= 1'b0;
      cycle_done       <= 1'b0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      async_mode       <= next_async_mode;
      // strobe falls on the done edge, which lets the partner drop ready
      strobe_active    <= (next_state != `EBRWC_ST_IDLE) &&
                          (next_state != `EBRWC_ST_DONE);
      ready_wait_phase <= (state == `EBRWC_ST_RDY || state == `EBRWC_ST_SYNC) &&
                          (next_state == `EBRWC_ST_RDY);
      cycle_done       <= (next_state == `EBRWC_ST_DONE);
    end
  end

endmodule

// File: bench/ebrwc_props.sv
// concurrent checks on the ready wait-state controller ports
`timescale 1ns/10ps
module ebrwc_props (
  input wire clk, rst, cycle_start, ready_ctrl_en, ready_active_high, ready_async_mode,
  input wire ready_pin, strobe_active, ready_wait_phase, cycle_done, busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_IDLE: assert property (!busy |-> !strobe_active && !cycle_done)
    else $error("idle output");
  AST_START: assert property ($rose(strobe_active) |-> $past(cycle_start))
    else $error("cycle without start");
  AST_MAND: assert property ($rose(strobe_active) && ready_ctrl_en
    |-> !ready_wait_phase ##0 !cycle_done[*2])
    else $error("mandatory waits cut");
  AST_ASYNC: assert property ($rose(strobe_active) && ready_async_mode && ready_ctrl_en
    |-> !cycle_done[*3])
    else $error("no sync wait");
  AST_END: assert property (cycle_done |-> !strobe_active ##1 !busy && !cycle_done)
    else $error("bad cycle end");
  AST_WAIT: assert property (ready_wait_phase |-> strobe_active)
    else $error("wait outside cycle");
  AST_GO: assert property ((ready_pin == ready_active_high)[*2] ##0 ready_wait_phase
    |-> ##[1:4] cycle_done)
    else $error("ready ignored");
  AST_HOLD: assert property ((ready_ctrl_en && ready_pin != ready_active_high)[*5]
    |=> !cycle_done)
    else $error("ended without ready");
  COV_ASYNC: cover property (cycle_done && ready_async_mode);
  COV_WAIT: cover property ($rose(ready_wait_phase));
  COV_LOW: cover property (cycle_done && !ready_active_high);
endmodule
bind ebrwc_ready_ctrl ebrwc_props chk (.*);

// File: bench/ebrwc_ready_partner.sv
// external circuit model answering on the ready pin
`timescale 1ns/10ps
module ebrwc_ready_partner (
  input  wire       clk, rst, strobe_active, pol,
  input  wire [3:0] dly,
  output reg        ready_pin
);
  reg [3:0] cnt;
  // ready kept active until strobe ends, so it lasts well over one period
  always @(posedge clk) begin
    cnt <= (rst || !strobe_active) ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
    ready_pin <= (!rst && strobe_active && cnt >= dly) ? pol : ~pol;
  end
endmodule

// File: bench/tb_top.sv
// self-checking bench: random cycles run in both ready modes
`timescale 1ns/10ps
module tb_top;
  reg         clk = 0, rst = 1, cycle_start = 0, pol = 1, am = 0, en = 1;
  reg  [3:0]  pl = 4'h0, mw = 4'h0, dly = 4'h0;
  reg  [31:0] lf = 97111;
  wire        rdy, sa, rw, done, busy, rco;
  integer     n_mismatch = 0, comparisons = 0, i, ns, na, ne, b, ws, wa, we, s1, s2, s3;
  initial forever #10 clk = ~clk;
  ebrwc_ready_ctrl uut (.clk(clk), .rst(rst), .cycle_start(cycle_start), .phase_len(pl),
    .mandatory_wait_phase(mw), .ready_ctrl_en(en), .ready_active_high(pol),
    .ready_async_mode(am), .ready_pin(rdy), .bus_reference_clock_out(rco), .strobe_active(sa),
    .ready_wait_phase(rw), .cycle_done(done), .busy(busy));
  ebrwc_ready_partner ext (.clk(clk), .rst(rst), .strobe_active(sa), .pol(pol), .dly(dly),
    .ready_pin(rdy));
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer lo(input [3:0] p, input [3:0] m);
    lo = p + ((m == 4'h0) ? 1 : m) + 2;
  endfunction
  task summarize; begin
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task bad(input integer c); begin
    n_mismatch = n_mismatch + 1;
    $display("[ERR] %0t unexpected value %0d", $time, c);
  end endtask
  // c counts cycles to done, w ready-wait samples, s strobe samples
  task run(output integer c, output integer w, output integer s); begin
    cycle_start <= 1'b1;
    @(posedge clk) cycle_start <= 1'b0;
    #1 c = 1;
    w = rw;
    s = sa;
    while (done !== 1'b1 && c < 60) begin
      @(posedge clk);
      #1 c = c + 1;
      w = w + rw;
      s = s + sa;
    end
    if (c >= 60) begin bad(c); summarize; end
  end endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 comparisons = comparisons + 1;
    if (rco !== clk) bad(0);
    for (i = 0; i < 16; i = i + 1) begin
      lf = nx(lf);
      @(posedge clk);
      pl <= (i == 0) ? 4'h0 : (i == 1) ? 4'hF : lf[3:0];
      mw <= (i == 0) ? 4'h0 : (i == 1) ? 4'hF : lf[7:4];
      dly <= {2'h0, lf[9:8]};
      pol <= lf[10];
      am <= 1'b0;
      en <= 1'b1;
      @(posedge clk) run(ns, ws, s1);
      @(posedge clk) am <= 1'b1;
      run(na, wa, s2);
      // a cycle that is not ready-controlled ends right after its mandatory waits
      @(posedge clk) begin am <= 1'b0; en <= 1'b0; end
      @(posedge clk) run(ne, we, s3);
      b = lo(pl, mw);
      comparisons = comparisons + 10;
      if (ns < b) bad(ns);
      if (ns > b + dly + 5) bad(ns);
      if (na !== ns + 1) bad(na);
      if (ws !== ns - b) bad(ws);
      if (wa !== na - b) bad(wa);
      if (ne !== b - 1) bad(ne);
      if (we !== 0) bad(we);
      if (s1 !== ns - 1) bad(s1);
      if (s2 !== na - 1) bad(s2);
      if (s3 !== ne - 1) bad(s3);
    end
    summarize;
  end
endmodule
